/* common/ocmp_pkg.sv */
package ocmp_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_PRIMARY   = 4'h4;
    localparam logic [3:0] ADDR_SECONDARY = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'hC;
    // irq mask sits at its own word; address bus is 5 bits wide
    localparam logic [4:0] ADDR_IRQ_MASK  = 5'h10;

    // control field positions
    localparam int BIT_ENABLE     = 15;
    localparam int BIT_IDLE_STOP  = 13;
    localparam int BIT_WIDE       = 5;
    localparam int BIT_FAULT      = 4;
    localparam int BIT_TSEL       = 3;
    localparam int MODE_LSB       = 0;

    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;

    // interrupt status bits
    localparam int IRQ_MATCH      = 0;
    localparam int IRQ_SECONDARY  = 1;
    localparam int IRQ_FAULT      = 2;
    localparam int IRQ_WIDTH      = 3;

    typedef enum logic [2:0] {
        MODE_OFF      = 3'h0,
        MODE_SET_HIGH = 3'h1,
        MODE_SET_LOW  = 3'h2,
        MODE_TOGGLE   = 3'h3,
        MODE_SINGLE   = 3'h4,
        MODE_CONT     = 3'h5,
        MODE_PWM      = 3'h6,
        MODE_PWM_FLT  = 3'h7
    } compare_mode_t;

    // one time base as seen by the channel
    typedef struct packed {
        logic [31:0] count;
        logic        rollover;
    } time_base_t;
endpackage

/* rtl/output_compare_channel.sv */
`timescale 1ns/10ps
// Function
// - channel works only while the enable bit is set; the fault interrupt is raised even while it is clear.
// - idle-stop bit halts the channel while the processor idles.
// - wide bit compares 32 bits, otherwise low 16 bits.
// - fault status set by a PWM fault, cleared by hardware only.
// - fault status reads zero outside PWM-with-fault mode.
// - timer select one picks second time base, zero the first.
// - only the first and second time bases feed the channel.
// - mode 111 is PWM with fault input enabled.
// - mode 110 is PWM with fault input ignored.
// - mode 101 drives pin low then pulses continuously.
// - mode 100 drives pin low then gives one pulse.
// - mode 011 toggles the pin on every match.
// - mode 010 starts pin high, forces low on match.
// - mode 001 starts pin low, forces high on match.
// - mode 000 disables compare, no output activity.
// - unimplemented control bits, upper half included, read as zero.
module output_compare_channel
    import ocmp_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire ocmp_pkg::time_base_t  time_base_first,
    input  wire ocmp_pkg::time_base_t  time_base_second,
    input  wire logic                  cpu_idle,
    input  wire logic                  fault_in_n,
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    output logic                       compare_output_pin,
    output logic                       irq
);
    import ocmp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0]          primary_compare_value;
    logic [31:0]          secondary_compare_value;
    logic                 enable;
    logic                 idle_stop;
    logic                 wide_compare;
    logic                 timer_select;
    compare_mode_t        compare_mode;
    logic                 fault_latched;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic                 single_done;
    logic                 ack;

    // write strobe: taken on the edge where waitrequest is low
    logic                 wr_take;
    logic                 rd_take;
    assign wr_take = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && !avs_waitrequest;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // time base select and match detect
    time_base_t tb;
    logic       run;
    logic       match_primary;
    logic       match_secondary;
    logic       fault_active;
    logic       pwm_mode;

    assign tb  = timer_select ? time_base_second : time_base_first;
    // idle halts only when idle_stop asks for it
    assign run = enable && !(idle_stop && cpu_idle);
    // upper half ignored in narrow mode
    assign match_primary = wide_compare ? (tb.count == primary_compare_value)
                         : (tb.count[15:0] == primary_compare_value[15:0]);
    assign match_secondary = wide_compare ? (tb.count == secondary_compare_value)
                           : (tb.count[15:0] == secondary_compare_value[15:0]);
    assign pwm_mode     = (compare_mode == MODE_PWM) || (compare_mode == MODE_PWM_FLT);
    assign fault_active = (compare_mode == MODE_PWM_FLT) && !fault_in_n;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle answer: waitrequest high for the first cycle of a request;
    // kept as the flop itself so the bus output has no gate behind it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end
    assign ack = !avs_waitrequest;

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable       <= CONTROL_RESET[BIT_ENABLE];
            idle_stop    <= CONTROL_RESET[BIT_IDLE_STOP];
            wide_compare <= CONTROL_RESET[BIT_WIDE];
            timer_select <= CONTROL_RESET[BIT_TSEL];
            compare_mode <= MODE_OFF;
        end else if (wr_take && avs_address == {1'b0, ADDR_CONTROL}) begin
            if (avs_byteenable[1]) begin
                enable    <= avs_writedata[BIT_ENABLE];
                idle_stop <= avs_writedata[BIT_IDLE_STOP];
            end
            if (avs_byteenable[0]) begin
                wide_compare <= avs_writedata[BIT_WIDE];
                timer_select <= avs_writedata[BIT_TSEL];
                compare_mode <= compare_mode_t'(avs_writedata[MODE_LSB +: 3]);
            end
        end
    end

    // compare value registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            primary_compare_value   <= COMPARE_RESET;
            secondary_compare_value <= COMPARE_RESET;
        end else if (wr_take) begin
            if (avs_address == {1'b0, ADDR_PRIMARY}) begin
                primary_compare_value <= be_merge(primary_compare_value,
                                                  avs_writedata, avs_byteenable);
            end
            if (avs_address == {1'b0, ADDR_SECONDARY}) begin
                secondary_compare_value <= be_merge(secondary_compare_value,
                                                    avs_writedata, avs_byteenable);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault status: software cannot clear; released once the fault
    // input goes away at a period rollover, or when leaving mode 111 or clearing the enable bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_latched <= 1'b0;
        end else if (compare_mode != MODE_PWM_FLT || !enable) begin
            fault_latched <= 1'b0;
        end else if (fault_active) begin
            fault_latched <= 1'b1;
        end else if (run && tb.rollover) begin
            fault_latched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pin behaviour per mode
    logic mode_written;
    assign mode_written = wr_take && avs_address == {1'b0, ADDR_CONTROL}
                          && avs_byteenable[0];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            compare_output_pin <= 1'b0;
            single_done        <= 1'b0;
        end else if (mode_written) begin
            // initial pin state of the new mode; only 010 starts high
            compare_output_pin <= (avs_writedata[MODE_LSB +: 3] == MODE_SET_LOW)
                                  && avs_writedata[BIT_ENABLE];
            single_done        <= 1'b0;
        end else if (!enable) begin
            compare_output_pin <= 1'b0;
            single_done        <= 1'b0;
        end else if (run) begin
            case (compare_mode)
                MODE_OFF: begin
                    compare_output_pin <= 1'b0;
                end
                MODE_SET_HIGH: begin
                    if (match_primary) compare_output_pin <= 1'b1;
                end
                MODE_SET_LOW: begin
                    if (match_primary) compare_output_pin <= 1'b0;
                end
                MODE_TOGGLE: begin
                    if (match_primary) compare_output_pin <= !compare_output_pin;
                end
                MODE_SINGLE: begin
                    // one pulse: rise at primary, fall at secondary, then stay low
                    if (!single_done && match_primary) begin
                        compare_output_pin <= 1'b1;
                    end else if (compare_output_pin && match_secondary) begin
                        compare_output_pin <= 1'b0;
                        single_done        <= 1'b1;
                    end
                end
                MODE_CONT: begin
                    if (match_primary) begin
                        compare_output_pin <= 1'b1;
                    end else if (match_secondary) begin
                        compare_output_pin <= 1'b0;
                    end
                end
                MODE_PWM, MODE_PWM_FLT: begin
                    // a latch left over from mode 111 must not gate plain pwm
                    if (compare_mode == MODE_PWM_FLT && (fault_active || fault_latched)) begin
                        compare_output_pin <= 1'b0;
                    end else if (tb.rollover) begin
                        compare_output_pin <= 1'b1;
                    end else if (match_secondary) begin
                        compare_output_pin <= 1'b0;
                    end
                end
                default: begin
                    compare_output_pin <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, cleared by reading status; a new event wins
    logic [IRQ_WIDTH-1:0] irq_event;
    logic                 stat_read;
    assign irq_event[IRQ_MATCH]     = run && (compare_mode != MODE_OFF) && !pwm_mode
                                      && match_primary;
    assign irq_event[IRQ_SECONDARY] = run && pwm_mode && tb.rollover;
    assign irq_event[IRQ_FAULT]     = fault_active && !fault_latched;
    assign stat_read = rd_take && avs_address == {1'b0, ADDR_IRQ_STAT};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (stat_read ? '0 : irq_status) | irq_event;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_mask <= '0;
        end else if (wr_take && avs_address == ADDR_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_read ? '0 : irq_status) | irq_event) & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered while waitrequest is high
    logic [31:0] control_view;
    always_comb begin
        control_view                 = 32'h0000_0000;
        control_view[BIT_ENABLE]     = enable;
        control_view[BIT_IDLE_STOP]  = idle_stop;
        control_view[BIT_WIDE]       = wide_compare;
        control_view[BIT_FAULT]      = fault_latched && (compare_mode == MODE_PWM_FLT);
        control_view[BIT_TSEL]       = timer_select;
        control_view[MODE_LSB +: 3]  = compare_mode;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            case (avs_address)
                {1'b0, ADDR_CONTROL}:   avs_readdata <= control_view;
                {1'b0, ADDR_PRIMARY}:   avs_readdata <= primary_compare_value;
                {1'b0, ADDR_SECONDARY}: avs_readdata <= secondary_compare_value;
                {1'b0, ADDR_IRQ_STAT}:  avs_readdata <= {29'h0, irq_status};
                ADDR_IRQ_MASK:          avs_readdata <= {29'h0, irq_mask};
                default:                avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_fault_zero;
        @(posedge clk_sys) disable iff (rst)
        (compare_mode != MODE_PWM_FLT) |-> !control_view[BIT_FAULT];
    endproperty
    a_fault_zero: assert property (p_fault_zero) else $error("fault bit outside mode 7");

    property p_off_low;
        @(posedge clk_sys) disable iff (rst)
        (!enable && !mode_written) |=> !compare_output_pin;
    endproperty
    a_off_low: assert property (p_off_low) else $error("pin active while disabled");

    property p_toggle;
        @(posedge clk_sys) disable iff (rst)
        (run && compare_mode == MODE_TOGGLE && match_primary && !mode_written)
        |=> compare_output_pin != $past(compare_output_pin);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_idle_hold;
        @(posedge clk_sys) disable iff (rst)
        (enable && idle_stop && cpu_idle && !mode_written) |=> $stable(compare_output_pin);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("pin moved in idle");

    property p_fault_set;
        @(posedge clk_sys) disable iff (rst)
        (run && fault_active && !mode_written) |=> fault_latched ##0 !compare_output_pin;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not latched");

    property p_pwm_rise;
        @(posedge clk_sys) disable iff (rst)
        (run && compare_mode == MODE_PWM && tb.rollover && !mode_written)
        |=> compare_output_pin;
    endproperty
    a_pwm_rise: assert property (p_pwm_rise) else $error("pwm did not rise");

    property p_set_high;
        @(posedge clk_sys) disable iff (rst)
        (run && compare_mode == MODE_SET_HIGH && match_primary && !mode_written)
        |=> compare_output_pin [*2];
    endproperty
    a_set_high: assert property (p_set_high) else $error("set high failed");

    property p_mode_off;
        @(posedge clk_sys) disable iff (rst)
        (run && compare_mode == MODE_OFF && !mode_written) |=> !compare_output_pin;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("activity in mode 0");

    property p_upper_zero;
        @(posedge clk_sys) disable iff (rst)
        ack && avs_read && avs_address == {1'b0, ADDR_CONTROL}
        |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper control nonzero");
endmodule // output_compare_channel

/* test/time_base_model.sv */
`timescale 1ns/10ps
module time_base_model
    import ocmp_pkg::*;
#(
    parameter int P1 = 40,
    parameter int P2 = 100
)(
    input  wire logic            clk_sys,
    input  wire logic            rst,
    output ocmp_pkg::time_base_t first,
    output ocmp_pkg::time_base_t second
);
    logic [15:0] n1;
    logic [15:0] n2;

    // two free counters; upper half of the second held at one, so a
    // narrow compare and a wide compare disagree on the same value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            n1 <= 16'h0000;
            n2 <= 16'h0000;
        end else begin
            n1 <= (n1 == 16'(P1 - 1)) ? 16'h0000 : n1 + 16'h0001;
            n2 <= (n2 == 16'(P2 - 1)) ? 16'h0000 : n2 + 16'h0001;
        end
    end

    // rollover is a one-cycle pulse on the last count of a period
    assign first  = '{count: {16'h0000, n1}, rollover: n1 == 16'(P1 - 1)};
    assign second = '{count: {16'h0001, n2}, rollover: n2 == 16'(P2 - 1)};
endmodule // time_base_model

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
    import ocmp_pkg::*;
    logic        clk_sys;
    logic        rst;
    time_base_t  tb1;
    time_base_t  tb2;
    logic        cpu_idle;
    logic        fault_in_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pin;
    logic        pin_d;
    logic        irq;
    logic [31:0] exp_q[$];
    logic [31:0] care_q[$];
    logic [31:0] seed;
    logic [31:0] prim;
    int          bad_count;
    int          checked;
    int          rises;
    int          cyc;

    time_base_model #(.P1(40), .P2(100)) time_base_model_inst (
        .clk_sys(clk_sys), .rst(rst), .first(tb1), .second(tb2));

    output_compare_channel output_compare_channel_inst (
        .clk_sys(clk_sys), .rst(rst), .time_base_first(tb1), .time_base_second(tb2),
        .cpu_idle(cpu_idle), .fault_in_n(fault_in_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .compare_output_pin(pin), .irq(irq));

    // 25 MHz
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (e !== g) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus cycle; a read notes its expectation and care mask first
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d, logic [31:0] cm);
        @(posedge clk_sys);
        if (!w) begin
            exp_q.push_back(d);
            care_q.push_back(cm);
        end
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wait_cnt(logic s, logic [15:0] v);
        do @(posedge clk_sys); while ((s ? tb2.count[15:0] : tb1.count[15:0]) !== v);
    endtask

    // sync away from the match, set mode, check initial and matched level
    task automatic mode_case(logic [31:0] c, logic [31:0] p, logic [15:0] w, logic i0,
                             logic i1);
        bus(1'b1, ADDR_PRIMARY, p, 32'h0);
        wait_cnt(c[BIT_TSEL], w + 16'h3);
        bus(1'b1, ADDR_CONTROL, c, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk("pin initial", i0, pin);
        wait_cnt(c[BIT_TSEL], w);
        repeat (3) @(posedge clk_sys);
        chk("pin after match", i1, pin);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // read results compared oldest note first, masked to the bits that matter
    always @(posedge clk_sys) begin : mon
        logic [31:0] e;
        logic [31:0] m;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            m = care_q.pop_front();
            chk("readdata", e & m, avs_readdata & m);
        end
    end

    // pulse edge counter and hang guard
    always @(posedge clk_sys) begin
        pin_d <= pin;
        if (pin === 1'b1 && pin_d === 1'b0) rises++;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        cpu_idle = 1'b0;
        fault_in_n = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        pin_d = 1'b0;
        seed = 32'hDAAE;
        bad_count = 0;
        checked = 0;
        rises = 0;
        cyc = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, ADDR_CONTROL, CONTROL_RESET, 32'hFFFF_FFFF);
        bus(1'b0, ADDR_PRIMARY, COMPARE_RESET, 32'hFFFF_FFFF);
        bus(1'b0, 5'h14, 32'h0, 32'hFFFF_FFFF);
        bus(1'b1, 5'h18, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, ADDR_CONTROL, 32'hFFFF_FFF8, 32'h0);
        bus(1'b0, ADDR_CONTROL, 32'h0000_A028, 32'hFFFF_FFFF);
        // byte lanes 0 and 2 only: the other lanes keep their reset zero
        avs_byteenable <= 4'h5;
        bus(1'b1, ADDR_PRIMARY, 32'hAABB_CCDD, 32'h0);
        avs_byteenable <= 4'hF;
        bus(1'b0, ADDR_PRIMARY, 32'h00BB_00DD, 32'hFFFF_FFFF);
        $display("test registers done");
        // enable plus mode code in the low bits
        prim = 32'h5 + rnd() % 32'h14;
        mode_case(32'h8001, prim, prim[15:0], 1'b0, 1'b1);
        prim = 32'h5 + rnd() % 32'h14;
        mode_case(32'h8002, prim, prim[15:0], 1'b1, 1'b0);
        mode_case(32'h8003, prim, prim[15:0], 1'b0, 1'b1);
        wait_cnt(1'b0, prim[15:0]);
        repeat (3) @(posedge clk_sys);
        chk("pin toggled back", 1'b0, pin);
        mode_case(32'h8000, prim, prim[15:0], 1'b0, 1'b0);
        // disabled channel, then idle with and without the idle-stop bit
        mode_case(32'h0001, prim, prim[15:0], 1'b0, 1'b0);
        cpu_idle <= 1'b1;
        mode_case(32'hA001, prim, prim[15:0], 1'b0, 1'b0);
        mode_case(32'h8001, prim, prim[15:0], 1'b0, 1'b1);
        cpu_idle <= 1'b0;
        $display("test modes done");
        mode_case(32'h8009, 32'h46, 16'h46, 1'b0, 1'b1);
        mode_case(32'h8001, 32'h46, 16'hA, 1'b0, 1'b0);
        mode_case(32'h8029, 32'h46, 16'h46, 1'b0, 1'b0);
        mode_case(32'h8029, 32'h0001_0046, 16'h46, 1'b0, 1'b1);
        $display("test time base done");
        bus(1'b1, ADDR_PRIMARY, 32'hA, 32'h0);
        bus(1'b1, ADDR_SECONDARY, 32'h14, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wait_cnt(1'b0, 16'h19);
            bus(1'b1, ADDR_CONTROL, 32'h8004 + k, 32'h0);
            rises = 0;
            repeat (3) wait_cnt(1'b0, 16'h19);
            chk("pulse count", k ? 3 : 1, rises);
        end
        $display("test pulses done");
        // fault input low must not matter in plain pwm
        fault_in_n <= 1'b0;
        bus(1'b1, ADDR_CONTROL, 32'h8006, 32'h0);
        wait_cnt(1'b0, 16'h5);
        wait_cnt(1'b0, 16'h5);
        chk("pwm high", 1'b1, pin);
        wait_cnt(1'b0, 16'h18);
        chk("pwm low", 1'b0, pin);
        bus(1'b0, ADDR_CONTROL, 32'h8006, 32'h10);
        chk("irq masked", 1'b0, irq);
        bus(1'b1, ADDR_IRQ_MASK, 32'h2, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq unmasked", 1'b1, irq);
        bus(1'b1, ADDR_IRQ_MASK, 32'h4, 32'h0);
        bus(1'b0, ADDR_IRQ_STAT, 32'h3, 32'h3);
        bus(1'b1, ADDR_CONTROL, 32'h8007, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk("irq fault", 1'b1, irq);
        chk("pin fault", 1'b0, pin);
        bus(1'b0, ADDR_IRQ_STAT, 32'h4, 32'h5);
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", 1'b0, irq);
        bus(1'b1, ADDR_CONTROL, 32'h8007, 32'h0);
        bus(1'b0, ADDR_CONTROL, 32'h8017, 32'hFFFF_FFFF);
        fault_in_n <= 1'b1;
        wait_cnt(1'b0, 16'h5);
        wait_cnt(1'b0, 16'h5);
        chk("pin resumes", 1'b1, pin);
        bus(1'b0, ADDR_CONTROL, 32'h8007, 32'hFFFF_FFFF);
        $display("test pwm done");
        summarize();
    end
endmodule // tb
